/* src/ahl_lister.sv */
// ASCII hex buffer lister: parses remote address/command text, lists the
// buffer as hex text, or loads it in the local program-with-newline format.
// Assumes: rx bytes are one-cycle strobes, tx handshake is valid/ready,
// buffer read data arrives within the cycle that presents the address.
`timescale 1ns/10ps
module ahl_lister (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [3:0] i_format,
	input wire logic i_local_go,
	input wire logic [15:0] i_local_start,
	input wire logic [15:0] i_local_end,
	input wire logic i_rx_vld,
	input wire logic [7:0] i_rx_data,
	output logic o_tx_vld,
	output logic [7:0] o_tx_data,
	input wire logic i_tx_rdy,
	output logic [15:0] o_buf_addr,
	input wire logic [7:0] i_buf_rdata,
	output logic o_buf_wr,
	output logic [7:0] o_buf_wdata,
	output logic o_busy
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic is_hex(input logic [7:0] c);
		is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
			|| (c >= 8'h61 && c <= 8'h66);
	endfunction : is_hex

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		if (c <= 8'h39) begin
			hex_val = c[3:0];
		end else begin
			hex_val = c[3:0] + 4'h9;
		end
	endfunction : hex_val

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		hex_chr = (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
	endfunction : hex_chr

	// Mode picked by a local format number; reserved numbers map to none
	function automatic ahl_pkg::ahl_mode_t fmt_mode(input logic [3:0] f);
		case (f)
			ahl_pkg::FMT_LINE: fmt_mode = ahl_pkg::MODE_LINE;
			ahl_pkg::FMT_BLOCK: fmt_mode = ahl_pkg::MODE_BLOCK;
			ahl_pkg::FMT_STREAM: fmt_mode = ahl_pkg::MODE_STREAM;
			ahl_pkg::FMT_PACED: fmt_mode = ahl_pkg::MODE_PACED;
			ahl_pkg::FMT_PROG_NL: fmt_mode = ahl_pkg::MODE_PROG;
			default: fmt_mode = ahl_pkg::MODE_NONE;
		endcase
	endfunction : fmt_mode

	ahl_pkg::ahl_state_s_t s_ff;
	ahl_pkg::ahl_state_s_t nxt_s;
	logic tx_go;
	logic end_reached;

	assign tx_go = s_ff.tx_vld && i_tx_rdy;
	assign end_reached = (s_ff.addr == s_ff.last);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		nxt_s.wr = 1'b0;
		if (tx_go) begin
			nxt_s.tx_vld = 1'b0;
		end
		case (s_ff.st)
			ahl_pkg::ST_ADDR: begin
				if (i_local_go && fmt_mode(i_format) != ahl_pkg::MODE_NONE) begin
					nxt_s.addr = i_local_start;
					nxt_s.last = i_local_end;
					nxt_s.mode = fmt_mode(i_format);
					nxt_s.cnt = 3'h0;
					nxt_s.done = 1'b0;
					nxt_s.hdr = 1'b1;
					nxt_s.lo_nib = 1'b0;
					if (fmt_mode(i_format) == ahl_pkg::MODE_PROG) begin
						nxt_s.st = ahl_pkg::ST_CR;
					end else begin
						nxt_s.st = ahl_pkg::ST_RD;
					end
				end else if (i_rx_vld && is_hex(i_rx_data)) begin
					// start digits fill first, then end digits
					if (!s_ff.cnt[2]) begin
						nxt_s.addr = {s_ff.addr[11:0], hex_val(i_rx_data)};
					end else begin
						nxt_s.last = {s_ff.last[11:0], hex_val(i_rx_data)};
					end
					nxt_s.cnt = s_ff.cnt + 3'h1;
					if (s_ff.cnt == 3'(ahl_pkg::ADDR_CHARS - 1)) begin
						nxt_s.st = ahl_pkg::ST_CMD;
					end
				end
			end
			ahl_pkg::ST_CMD: begin
				if (i_rx_vld) begin
					nxt_s.cnt = 3'h0;
					nxt_s.done = 1'b0;
					nxt_s.hdr = 1'b1;
					nxt_s.st = ahl_pkg::ST_RD;
					nxt_s.lo_nib = 1'b0;
					// remote letters never reach program mode
					case (i_rx_data)
						ahl_pkg::CMD_LINE: nxt_s.mode = ahl_pkg::MODE_LINE;
						ahl_pkg::CMD_BLOCK: nxt_s.mode = ahl_pkg::MODE_BLOCK;
						ahl_pkg::CMD_STREAM: nxt_s.mode = ahl_pkg::MODE_STREAM;
						ahl_pkg::CMD_PACED: nxt_s.mode = ahl_pkg::MODE_PACED;
						default: begin
							nxt_s.mode = ahl_pkg::MODE_NONE;
							nxt_s.st = ahl_pkg::ST_ADDR;
						end
					endcase
				end
			end
			ahl_pkg::ST_RD: begin
				// Block header and line address are sent ahead of the data
				if (!s_ff.tx_vld || tx_go) begin
					if (s_ff.mode == ahl_pkg::MODE_BLOCK && s_ff.lo_nib == 1'b0
						&& (s_ff.hdr || s_ff.addr[3:0] == 4'h0)) begin
						nxt_s.tx = ahl_pkg::CH_SLASH;
						nxt_s.tx_vld = 1'b1;
						nxt_s.lo_nib = 1'b1;
						nxt_s.cnt = 3'h0;
					end else if (s_ff.mode == ahl_pkg::MODE_BLOCK
						&& s_ff.lo_nib && s_ff.cnt != 3'h4) begin
						nxt_s.tx = hex_chr(s_ff.addr[4'(15 - 4 * s_ff.cnt) -: 4]);
						nxt_s.tx_vld = 1'b1;
						nxt_s.cnt = s_ff.cnt + 3'h1;
					end else begin
						nxt_s.hdr = 1'b0;
						nxt_s.st = ahl_pkg::ST_HI;
						nxt_s.data = i_buf_rdata;
						if (s_ff.mode == ahl_pkg::MODE_BLOCK && s_ff.lo_nib) begin
							nxt_s.tx = ahl_pkg::CH_SP;
							nxt_s.tx_vld = 1'b1;
						end
					end
				end
			end
			ahl_pkg::ST_HI: begin
				if (!s_ff.tx_vld || tx_go) begin
					nxt_s.tx = hex_chr(s_ff.data[7:4]);
					nxt_s.tx_vld = 1'b1;
					nxt_s.st = ahl_pkg::ST_LO;
				end
			end
			ahl_pkg::ST_LO: begin
				if (tx_go) begin
					nxt_s.tx = hex_chr(s_ff.data[3:0]);
					nxt_s.tx_vld = 1'b1;
					nxt_s.done = end_reached;
					nxt_s.st = (s_ff.mode == ahl_pkg::MODE_STREAM)
						? ahl_pkg::ST_CR : ahl_pkg::ST_SEP;
				end
			end
			ahl_pkg::ST_SEP: begin
				if (tx_go) begin
					nxt_s.tx = ahl_pkg::CH_SP;
					nxt_s.tx_vld = 1'b1;
					nxt_s.st = (s_ff.addr[3:0] == ahl_pkg::LINE_LAST || s_ff.done)
						? ahl_pkg::ST_CR : ahl_pkg::ST_XON;
				end
			end
			ahl_pkg::ST_CR: begin
				// Stream and non-line-end bytes skip the line ending
				if (s_ff.mode == ahl_pkg::MODE_STREAM) begin
					if (tx_go) begin
						nxt_s.addr = s_ff.addr + 16'h1;
						nxt_s.st = s_ff.done ? ahl_pkg::ST_ADDR : ahl_pkg::ST_RD;
						nxt_s.cnt = 3'h0;
					end
				end else if (!s_ff.tx_vld || tx_go) begin
					nxt_s.tx = ahl_pkg::CH_CR;
					nxt_s.tx_vld = 1'b1;
					nxt_s.st = ahl_pkg::ST_LF;
				end
			end
			ahl_pkg::ST_LF: begin
				if (tx_go) begin
					nxt_s.tx = ahl_pkg::CH_LF;
					nxt_s.tx_vld = 1'b1;
					nxt_s.st = ahl_pkg::ST_XON;
				end
			end
			ahl_pkg::ST_XON: begin
				if (!s_ff.tx_vld) begin
					if (s_ff.mode == ahl_pkg::MODE_PROG) begin
						nxt_s.cnt = 3'h0;
						nxt_s.st = s_ff.done ? ahl_pkg::ST_ADDR : ahl_pkg::ST_PROG;
					end else if (s_ff.done) begin
						nxt_s.st = ahl_pkg::ST_ADDR;
						nxt_s.cnt = 3'h0;
					end else if (s_ff.mode == ahl_pkg::MODE_PACED
						&& s_ff.addr[3:0] == ahl_pkg::LINE_LAST) begin
						// only a finished line waits for XON
						if (i_rx_vld && i_rx_data == ahl_pkg::CH_XON) begin
							nxt_s.addr = s_ff.addr + 16'h1;
							nxt_s.st = ahl_pkg::ST_RD;
						end
					end else begin
						nxt_s.addr = s_ff.addr + 16'h1;
						nxt_s.lo_nib = 1'b0;
						nxt_s.hdr = (s_ff.addr[7:0] == ahl_pkg::BLOCK_LAST);
						nxt_s.st = ahl_pkg::ST_RD;
					end
				end
			end
			ahl_pkg::ST_PROG: begin
				// Non-hex characters between digits are ignored
				// Address steps after the write, so the strobe sees its own
				if (s_ff.wr) begin
					nxt_s.addr = s_ff.addr + 16'h1;
				end
				if (i_rx_vld && is_hex(i_rx_data)) begin
					nxt_s.lo_nib = ~s_ff.lo_nib;
					nxt_s.data = {s_ff.data[3:0], hex_val(i_rx_data)};
					if (s_ff.lo_nib) begin
						nxt_s.wr = 1'b1;
						nxt_s.wdata = {s_ff.data[3:0], hex_val(i_rx_data)};
						nxt_s.done = end_reached;
						nxt_s.st = end_reached ? ahl_pkg::ST_CR : ahl_pkg::ST_PROG;
					end
				end
			end
			default: nxt_s.st = ahl_pkg::ST_ADDR;
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_ff <= '{st: ahl_pkg::ST_ADDR, mode: ahl_pkg::MODE_NONE,
				default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_tx_vld = s_ff.tx_vld;
	assign o_tx_data = s_ff.tx;
	assign o_buf_addr = s_ff.addr;
	assign o_buf_wr = s_ff.wr;
	assign o_buf_wdata = s_ff.wdata;
	assign o_busy = (s_ff.st != ahl_pkg::ST_ADDR) && (s_ff.st != ahl_pkg::ST_CMD);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_stream_nosep: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.mode == ahl_pkg::MODE_STREAM && o_tx_vld)
		|-> o_tx_data != ahl_pkg::CH_SP)
		else $error("stream mode sent a separator");
	a_paced_waits: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.st == ahl_pkg::ST_XON && s_ff.mode == ahl_pkg::MODE_PACED
		&& !s_ff.tx_vld && !s_ff.done && s_ff.addr[3:0] == 4'hf
		&& !(i_rx_vld && i_rx_data == ahl_pkg::CH_XON))
		|=> s_ff.st == ahl_pkg::ST_XON)
		else $error("paced line released without XON");
	a_addr_collect: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.st == ahl_pkg::ST_ADDR && s_ff.cnt == 3'h7 && !i_local_go
		&& i_rx_vld && is_hex(i_rx_data)) |=> s_ff.st == ahl_pkg::ST_CMD)
		else $error("eighth address digit did not reach command wait");
	a_no_remote_prog: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.st == ahl_pkg::ST_CMD && i_rx_vld)
		|=> s_ff.mode != ahl_pkg::MODE_PROG)
		else $error("remote letter chose program mode");
	a_reserved_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.st == ahl_pkg::ST_ADDR && i_local_go && i_format >= 4'h7)
		|=> !o_busy)
		else $error("reserved format started an operation");
	a_line_cmd: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.st == ahl_pkg::ST_CMD && i_rx_vld && i_rx_data == ahl_pkg::CMD_LINE)
		|=> s_ff.mode == ahl_pkg::MODE_LINE && o_busy)
		else $error("L did not start line list");
	a_prog_crlf: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ff.st == ahl_pkg::ST_ADDR && i_local_go && i_format == 4'h6)
		|=> s_ff.st == ahl_pkg::ST_CR)
		else $error("program mode did not begin with CR");
	a_lf_after_cr: assert property (@(posedge i_clk) disable iff (i_rst)
		(o_tx_vld && i_tx_rdy && o_tx_data == ahl_pkg::CH_CR
		&& s_ff.st == ahl_pkg::ST_LF) |=> o_tx_vld && o_tx_data == ahl_pkg::CH_LF)
		else $error("CR not followed by LF");

endmodule : ahl_lister

/* src/ahl_pkg.sv */
// Package for the ASCII hex buffer lister: formats, characters, states.
// Assumes a byte-wide serial link and a 16-bit addressed byte buffer.
package ahl_pkg;

	// ------------------------------------------------------------
	// Characters
	// ------------------------------------------------------------
	localparam logic [7:0] CH_CR = 8'h0d;
	localparam logic [7:0] CH_LF = 8'h0a;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_XON = 8'h11;
	localparam logic [7:0] CH_SLASH = 8'h2f;
	localparam logic [7:0] CMD_LINE = 8'h4c;
	localparam logic [7:0] CMD_BLOCK = 8'h4d;
	localparam logic [7:0] CMD_STREAM = 8'h4e;
	localparam logic [7:0] CMD_PACED = 8'h58;

	// ------------------------------------------------------------
	// Layout and format numbers
	// ------------------------------------------------------------
	localparam int ADDR_CHARS = 8;
	localparam logic [3:0] LINE_LAST = 4'hf;
	localparam logic [7:0] BLOCK_LAST = 8'hff;
	localparam logic [3:0] FMT_LINE = 4'h2;
	localparam logic [3:0] FMT_BLOCK = 4'h3;
	localparam logic [3:0] FMT_STREAM = 4'h4;
	localparam logic [3:0] FMT_PACED = 4'h5;
	localparam logic [3:0] FMT_PROG_NL = 4'h6;

	typedef enum logic [3:0] {
		MODE_NONE = 4'h0,
		MODE_LINE = 4'h1,
		MODE_BLOCK = 4'h2,
		MODE_STREAM = 4'h3,
		MODE_PACED = 4'h4,
		MODE_PROG = 4'h5
	} ahl_mode_t;

	typedef enum logic [9:0] {
		ST_ADDR = 10'h001,
		ST_CMD = 10'h002,
		ST_RD = 10'h004,
		ST_HI = 10'h008,
		ST_LO = 10'h010,
		ST_SEP = 10'h020,
		ST_CR = 10'h040,
		ST_LF = 10'h080,
		ST_XON = 10'h100,
		ST_PROG = 10'h200
	} ahl_state_t;

	typedef struct packed {
		ahl_state_t st;
		ahl_mode_t mode;
		logic [15:0] addr;
		logic [15:0] last;
		logic [2:0] cnt;
		logic [7:0] data;
		logic lo_nib;
		logic done;
		logic hdr;
		logic [7:0] tx;
		logic tx_vld;
		logic wr;
		logic [7:0] wdata;
	} ahl_state_s_t;

endpackage : ahl_pkg

/* verif/ahl_lister_test.sv */
// Self-checking bench for the ASCII hex buffer lister.
// Assumes buffer byte at an address equals its low address byte.
`timescale 1ns/10ps
module ahl_lister_test;
	logic clk, rst, slow, go, rx_vld, tx_vld, tx_rdy, buf_wr, busy;
	logic [3:0] fmt;
	logic [15:0] ls, le, baddr;
	logic [7:0] rx_data, tx_data, rdata, wdata;
	logic [15:0] wa[$];
	logic [7:0] wd[$];
	logic [7:0] exp[$];
	int miscompares, compares, cyc;

	ahl_lister dut (.i_clk(clk), .i_rst(rst), .i_format(fmt),
		.i_local_go(go), .i_local_start(ls), .i_local_end(le),
		.i_rx_vld(rx_vld), .i_rx_data(rx_data), .o_tx_vld(tx_vld),
		.o_tx_data(tx_data), .i_tx_rdy(tx_rdy), .o_buf_addr(baddr),
		.i_buf_rdata(rdata), .o_buf_wr(buf_wr), .o_buf_wdata(wdata),
		.o_busy(busy));
	ahl_remote_model rm (.i_clk(clk), .i_rst(rst), .i_slow(slow),
		.i_tx_vld(tx_vld), .i_tx_data(tx_data), .o_tx_rdy(tx_rdy),
		.o_rx_vld(rx_vld), .o_rx_data(rx_data));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Buffer answers half a cycle after the address, as the design expects
	always @(negedge clk) rdata <= baddr[7:0];
	always @(posedge clk) begin
		if (buf_wr === 1'b1) begin
			wa.push_back(baddr);
			wd.push_back(wdata);
		end
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input string nm, input logic [15:0] seen, ev);
		compares++;
		if (seen !== ev) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, ev, seen);
		end
	endtask : check

	task automatic cmp_out(input string nm);
		check({nm, " count"}, 16'(rm.got.size()), 16'(exp.size()));
		foreach (exp[i]) begin
			if (i < rm.got.size()) check(nm, 16'(rm.got[i]), 16'(exp[i]));
		end
	endtask : cmp_out

	// Expected list text; sep adds spaces and a CR LF per 16 bytes or at end
	task automatic build(input logic [15:0] s, e, input logic sep);
		logic [15:0] a;
		int n;
		exp.delete();
		a = s;
		n = 0;
		forever begin
			exp.push_back(rm.hx(a[7:4]));
			exp.push_back(rm.hx(a[3:0]));
			if (sep) exp.push_back(8'h20);
			n++;
			if (sep && (n % 16 == 0 || a == e)) begin
				exp.push_back(8'h0d);
				exp.push_back(8'h0a);
			end
			if (a == e) break;
			a++;
		end
	endtask : build

	// Expected text from a string; a bar stands for CR LF
	task automatic exp_str(input string s);
		exp.delete();
		foreach (s[i]) begin
			if (s[i] == "|") begin
				exp.push_back(8'h0d);
				exp.push_back(8'h0a);
			end else begin
				exp.push_back(s[i]);
			end
		end
	endtask : exp_str

	task automatic wait_idle();
		int k;
		k = 0;
		@(negedge clk);
		while (busy !== 1'b0 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		check("idle", 16'(busy), 16'h0000);
	endtask : wait_idle

	task automatic wait_count(input int n);
		int k;
		k = 0;
		while (rm.got.size() < n && k < 5000) begin
			@(negedge clk);
			k++;
		end
	endtask : wait_count

	task automatic local_go(input logic [3:0] f, input logic [15:0] s, e);
		rm.got.delete();
		@(negedge clk);
		fmt = f;
		ls = s;
		le = e;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
	endtask : local_go

	task automatic t_bad_letter();
		rm.got.delete();
		rm.send_cmd(16'h0000, 16'h0001, 8'h50);
		repeat (20) @(negedge clk);
		check("bad letter out", 16'(rm.got.size()), 16'h0000);
		check("bad letter busy", 16'(busy), 16'h0000);
	endtask : t_bad_letter

	task automatic t_line();
		rm.got.delete();
		rm.send_cmd(16'h0000, 16'h0011, ahl_pkg::CMD_LINE);
		wait_idle();
		build(16'h0000, 16'h0011, 1'b1);
		cmp_out("line");
	endtask : t_line

	task automatic t_stream();
		rm.got.delete();
		slow = 1'b1;
		rm.send_cmd(16'h07fe, 16'h0803, ahl_pkg::CMD_STREAM);
		wait_idle();
		slow = 1'b0;
		build(16'h07fe, 16'h0803, 1'b0);
		cmp_out("stream");
	endtask : t_stream

	task automatic t_paced();
		rm.got.delete();
		rm.send_cmd(16'h0000, 16'h0011, ahl_pkg::CMD_PACED);
		wait_count(50);
		repeat (40) @(negedge clk);
		check("paced first", 16'(rm.got.size()), 16'd50);
		check("paced wait busy", 16'(busy), 16'h0001);
		rm.send(ahl_pkg::CH_XON);
		wait_idle();
		build(16'h0000, 16'h0011, 1'b1);
		cmp_out("paced");
	endtask : t_paced

	task automatic t_block();
		int k;
		// A one-byte block leaves the line-address flag set behind it
		local_go(ahl_pkg::FMT_BLOCK, 16'h0040, 16'h0040);
		wait_idle();
		exp_str("/0040 40 |");
		cmp_out("local block");
		rm.got.delete();
		rm.send_cmd(16'h00fe, 16'h0101, ahl_pkg::CMD_BLOCK);
		wait_idle();
		exp_str("/00FE FE FF |/0100 00 01 |");
		cmp_out("block");
		check("block head", 16'(rm.got[0]), 16'(ahl_pkg::CH_SLASH));
		k = rm.got.size() - 1;
		while (k > 1 && rm.got[k] inside {8'h0d, 8'h0a, 8'h20}) k--;
		check("block end", {rm.got[k - 1], rm.got[k]}, 16'h3031);
	endtask : t_block

	task automatic t_local();
		local_go(ahl_pkg::FMT_LINE, 16'h0000, 16'h0011);
		wait_idle();
		build(16'h0000, 16'h0011, 1'b1);
		cmp_out("local line");
		local_go(ahl_pkg::FMT_STREAM, 16'h0000, 16'h0001);
		wait_idle();
		build(16'h0000, 16'h0001, 1'b0);
		cmp_out("local stream");
		local_go(ahl_pkg::FMT_PACED, 16'h0000, 16'h0001);
		wait_idle();
		build(16'h0000, 16'h0001, 1'b1);
		cmp_out("local paced");
		for (int f = 7; f <= 9; f++) begin
			local_go(4'(f), 16'h0000, 16'h0011);
			repeat (10) @(negedge clk);
			check("reserved", {15'h0, busy} | 16'(rm.got.size()), 16'h0000);
		end
	endtask : t_local

	task automatic t_prog();
		string d;
		d = "A5x3C";
		local_go(ahl_pkg::FMT_PROG_NL, 16'h0020, 16'h0021);
		wait_count(2);
		check("prog open", {rm.got[0], rm.got[1]}, 16'h0d0a);
		foreach (d[i]) rm.send(d[i]);
		wait_idle();
		check("prog writes", 16'(wa.size()), 16'd2);
		check("prog a0", wa[0], 16'h0020);
		check("prog d0", 16'(wd[0]), 16'h00a5);
		check("prog a1", wa[1], 16'h0021);
		check("prog d1", 16'(wd[1]), 16'h003c);
		check("prog close", {rm.got[2], rm.got[3]}, 16'h0d0a);
	endtask : t_prog

	initial begin
		rst = 1'b1;
		slow = 1'b0;
		go = 1'b0;
		fmt = 4'h0;
		ls = 16'h0000;
		le = 16'h0000;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		t_bad_letter();
		t_line();
		t_stream();
		t_paced();
		t_block();
		t_local();
		t_prog();
		give_verdict();
	end
endmodule : ahl_lister_test

/* verif/ahl_remote_model.sv */
// Remote terminal model: sends address and command text to the lister
// and collects every character that the lister hands to the link.
// Assumes one shared clock; the model changes its outputs on the falling edge.
`timescale 1ns/10ps
module ahl_remote_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_slow,
	input wire logic i_tx_vld,
	input wire logic [7:0] i_tx_data,
	output logic o_tx_rdy,
	output logic o_rx_vld,
	output logic [7:0] o_rx_data
);
	logic [7:0] got[$];

	initial begin
		o_tx_rdy = 1'b0;
		o_rx_vld = 1'b0;
		o_rx_data = 8'h00;
	end

	// Slow mode accepts every other cycle, so held characters are exercised
	always @(negedge i_clk) begin
		o_tx_rdy <= i_slow ? ~o_tx_rdy : 1'b1;
	end

	always @(posedge i_clk) begin
		if (!i_rst && i_tx_vld && o_tx_rdy) begin
			got.push_back(i_tx_data);
		end
	end

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'ha) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction : hx

	// Idle data line shows the inverse of the last character, not a copy
	task automatic send(input logic [7:0] c);
		@(negedge i_clk);
		o_rx_vld = 1'b1;
		o_rx_data = c;
		@(negedge i_clk);
		o_rx_vld = 1'b0;
		o_rx_data = ~c;
	endtask : send

	task automatic send_cmd(input logic [15:0] s, e, input logic [7:0] c);
		logic [31:0] v;
		v = {s, e};
		for (int i = 0; i < 8; i++) begin
			send(hx(v[31 - 4 * i -: 4]));
		end
		send(c);
	endtask : send_cmd
endmodule : ahl_remote_model
